// File: pci_dev_cfg.svh
// offsets, reset values, field positions and counts of the device-specific configuration registers
`ifndef PCI_DEV_CFG_SVH
`define PCI_DEV_CFG_SVH

`define CFG_OFF_INT_LINE      8'h3c
`define CFG_OFF_INT_PIN       8'h3d
`define CFG_OFF_GRANT_HINT    8'h3e
`define CFG_OFF_LAT_HINT      8'h3f
`define CFG_OFF_TRDY_TO       8'h40
`define CFG_OFF_RETRY_TO      8'h41
`define CFG_OFF_RELEASE       8'h60
`define CFG_OFF_FRAME_LENGTH_ADJUST         8'h61
`define CFG_OFF_WAKE_MASK     8'h62
`define CFG_OFF_PM_CAP        8'hdc
`define CFG_OFF_PM_NEXT       8'hdd

`define RST_INT_PIN           8'h01
`define RST_TRDY_TO           8'h00
`define RST_RETRY_TO          8'h80
`define RST_RELEASE           8'h20
`define RST_FRAME_LENGTH_ADJUST             8'h20
`define RST_WAKE_MASK         16'h0007
`define RST_PM_POWER_CAP_IDENTIFIER         8'h01
`define RST_PM_NEXT           8'h00

`define FS_GRANT_HINT         8'h01
`define HS_GRANT_HINT         8'h02
`define FS_LAT_HINT           8'h2a
`define HS_LAT_HINT           8'h10
`define HINT_UNIT_NS          250
`define HINT_BUS_MHZ          33

`define TRDY_LIMIT_W          13
`define TRDY_LIMIT_LSB        5
`define FRAME_LENGTH_ADJUST_W               6
`define FRAME_LENGTH_ADJUST_RSV_MASK        8'hc0
`define SOF_BASE_CYCLES       17'd59488
`define SOF_CNT_W             17

`endif

// File: pci_dev_pkg.sv
// types shared by the configuration register bank
package pci_dev_pkg;
    typedef logic [31:0] dword_t;
    typedef logic [7:0]  byte_t;
    typedef logic [12:0] limit_t;
    typedef logic [16:0] sof_cnt_t;
endpackage

// File: timeout_mon_if.sv
// carrier between the register bank and one time-out monitor
`timescale 1ns/1ns
`default_nettype none
interface timeout_mon_if;
    import pci_dev_pkg::*;
    logic   restart;
    logic   step;
    limit_t limit;
    logic   expired;
    modport bank (output restart, output step, output limit, input expired);
    modport mon  (input restart, input step, input limit, output expired);
endinterface
`default_nettype wire

// File: timeout_mon.sv
// counts steps within one transaction and pulses when the count passes the limit
`timescale 1ns/1ns
`default_nettype none
module timeout_mon
    import pci_dev_pkg::*;
#(
    parameter int CNT_W = 13
) (
    input  wire logic  clk_i,   // bus clock
    input  wire logic  nrst_i,  // async reset, low
    timeout_mon_if.mon mon      // restart, step, limit, expired
);
    initial begin
        if (CNT_W < 13) begin
            $error("timeout_mon needs at least 13 count bits");
        end
    end

    logic [CNT_W-1:0] cnt_q;
    logic             fired_q;

    // restart clears the count so a limit spans one transaction only
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= '0;
        end else if (mon.restart) begin
            cnt_q <= '0;
        end else if (mon.step && cnt_q != '1) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // one report per transaction; a zero limit disables checking
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fired_q <= 1'b0;
        end else if (mon.restart) begin
            fired_q <= 1'b0;
        end else if (mon.expired) begin
            fired_q <= 1'b0 | 1'b1;
        end
    end

    assign mon.expired = !fired_q && (mon.limit != '0)
                         && (cnt_q > CNT_W'(mon.limit));
endmodule // timeout_mon
`default_nettype wire

// File: pci_config_device_regs.sv
// device-specific configuration registers, bus monitors and microframe timer
`timescale 1ns/1ns
`default_nettype none
`include "pci_dev_cfg.svh"

// Contract
// - interrupt pin byte is read-only and reads 1, meaning the first interrupt line.
// - grant and latency hints count in 250 ns units; zero means no demand.
// - read-only grant hint is 1 for full-speed, 2 for high-speed function.
// - target-ready time-out byte at 40h is writable, resets to zero, zero disables.
// - target-ready limit is the byte shifted up by five, in bus clocks.
// - target-ready wait beyond the limit sets the unrecoverable-error flag.
// - retry time-out byte at 41h is writable, resets to 80h, zero disables.
// - retries beyond the retry limit set the unrecoverable-error flag.
// - high-speed function reads release number 20h at 60h.
// - microframe lasts 59488 plus six-bit adjust value counter clocks.
// - a new adjust value retunes the length of the frame in progress and of following frames.
// - adjust field at 61h bits 5..0 resets to 32, giving 59520 clocks.
// - 16-bit wake mask at 62h resets to 0007h and steers nothing.
// - capability identifier reads 01h at the capability pointer location.
// - next-item pointer follows the identifier and reads zero.
module pci_config_device_regs
    import pci_dev_pkg::*;
#(
    parameter bit HS_FUNC = 1'b1   // 1: high-speed function, 0: full-speed function
) (
    input  wire logic         clk_i,          // bus clock
    input  wire logic         nrst_i,         // bus reset, async, low
    input  wire logic         cfg_req_i,      // configuration access strobe
    input  wire logic         cfg_we_i,       // 1 write, 0 read
    input  wire logic [7:0]   cfg_addr_i,     // byte address, bits 1..0 ignored
    input  wire logic [3:0]   cfg_be_i,       // byte enables
    input  wire logic [31:0]  cfg_wdata_i,    // write data
    output logic              cfg_ack_o,      // access done, one cycle
    output logic      [31:0]  cfg_rdata_o,    // read data
    input  wire logic         txn_start_i,    // new bus transaction begins
    input  wire logic         trdy_wait_i,    // target-ready still pending this cycle
    input  wire logic         retry_i,        // one retry seen this cycle
    input  wire logic         err_clear_i,    // clears the unrecoverable-error flag
    output logic              unrecoverable_error_flag_o, // sticky error status
    input  wire logic         sof_clk_en_i,   // microframe counter clock enable
    output logic              sof_o,          // microframe start pulse
    output logic      [7:0]   interrupt_pin_select_o // interrupt line in use
);
    initial begin
        if (HS_FUNC !== 1'b0 && HS_FUNC !== 1'b1) begin
            $error("HS_FUNC must be 0 or 1");
        end
    end

    // both hints count in 250 ns units; zero would mean no demand on latency timers
    localparam byte_t GRANT_HINT = HS_FUNC ? `HS_GRANT_HINT : `FS_GRANT_HINT;
    localparam byte_t LAT_HINT   = HS_FUNC ? `HS_LAT_HINT : `FS_LAT_HINT;

    byte_t            trdy_to_q;
    byte_t            retry_to_q;
    byte_t            frame_length_adjust_q;
    logic [15:0]      wake_mask_q;
    logic             ue_q;
    logic             ack_q;
    dword_t           rdata_q;
    sof_cnt_t         sof_cnt_q;
    logic             sof_q;

    logic             wr;
    logic [5:0]       dw;
    dword_t           rd_word;

    assign wr = cfg_req_i && cfg_we_i;
    assign dw = cfg_addr_i[7:2];

    // writable bytes, each lane gated by its enable
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            trdy_to_q  <= `RST_TRDY_TO;
            retry_to_q <= `RST_RETRY_TO;
        end else if (wr && dw == `CFG_OFF_TRDY_TO >> 2) begin
            if (cfg_be_i[0]) begin
                trdy_to_q <= cfg_wdata_i[7:0];
            end
            if (cfg_be_i[1]) begin
                retry_to_q <= cfg_wdata_i[15:8];
            end
        end
    end

    // high-speed function block; absent in full-speed functions
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            frame_length_adjust_q     <= `RST_FRAME_LENGTH_ADJUST;
            wake_mask_q <= `RST_WAKE_MASK;
        end else if (HS_FUNC && wr && dw == `CFG_OFF_RELEASE >> 2) begin
            if (cfg_be_i[1]) begin
                frame_length_adjust_q <= cfg_wdata_i[15:8];
            end
            if (cfg_be_i[2]) begin
                wake_mask_q[7:0] <= cfg_wdata_i[23:16];
            end
            if (cfg_be_i[3]) begin
                wake_mask_q[15:8] <= cfg_wdata_i[31:24];
            end
        end
    end

    // read mux; unmapped words and bytes outside this bank read as zero
    always_comb begin
        rd_word = '0;
        unique case (dw)
            6'(`CFG_OFF_INT_LINE >> 2): begin
                rd_word = {LAT_HINT, GRANT_HINT, byte_t'(`RST_INT_PIN), 8'h00};
            end
            6'(`CFG_OFF_TRDY_TO >> 2): begin
                rd_word = {16'h0000, retry_to_q, trdy_to_q};
            end
            6'(`CFG_OFF_RELEASE >> 2): begin
                if (HS_FUNC) begin
                    rd_word = {wake_mask_q, frame_length_adjust_q, byte_t'(`RST_RELEASE)};
                end
            end
            6'(`CFG_OFF_PM_CAP >> 2): begin
                rd_word = {16'h0000, byte_t'(`RST_PM_NEXT), byte_t'(`RST_PM_POWER_CAP_IDENTIFIER)};
            end
            default: begin
                rd_word = '0;
            end
        endcase
    end

    // every access answers one cycle after its strobe
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_q   <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q <= cfg_req_i;
            if (cfg_req_i && !cfg_we_i) begin
                rdata_q <= rd_word;
            end
        end
    end

    assign cfg_ack_o   = ack_q;
    assign cfg_rdata_o = rdata_q;
    assign interrupt_pin_select_o = `RST_INT_PIN;

    // bus monitors
    timeout_mon_if trdy_mon ();
    timeout_mon_if retry_mon ();

    assign trdy_mon.restart  = txn_start_i;
    assign trdy_mon.step     = trdy_wait_i;
    assign trdy_mon.limit    = {trdy_to_q, `TRDY_LIMIT_LSB'(0)};
    assign retry_mon.restart = txn_start_i;
    assign retry_mon.step    = retry_i;
    assign retry_mon.limit   = limit_t'(retry_to_q);

    timeout_mon #(
        .CNT_W (`TRDY_LIMIT_W)
    ) u_trdy_mon (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .mon    (trdy_mon.mon)
    );

    timeout_mon #(
        .CNT_W (`TRDY_LIMIT_W)
    ) u_retry_mon (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .mon    (retry_mon.mon)
    );

    // sticky error status; a new expiry wins over a clear in the same cycle
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ue_q <= 1'b0;
        end else if (trdy_mon.expired || retry_mon.expired) begin
            ue_q <= 1'b1;
        end else if (err_clear_i) begin
            ue_q <= 1'b0;
        end
    end

    assign unrecoverable_error_flag_o = ue_q;

    // microframe timer; the length follows the live adjust value
    sof_cnt_t frame_last;
    assign frame_last = `SOF_BASE_CYCLES + sof_cnt_t'(frame_length_adjust_q[`FRAME_LENGTH_ADJUST_W-1:0]) - 17'd1;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sof_cnt_q <= '0;
            sof_q     <= 1'b0;
        end else begin
            sof_q <= 1'b0;
            if (HS_FUNC && sof_clk_en_i) begin
                if (sof_cnt_q >= frame_last) begin
                    sof_cnt_q <= '0;
                    sof_q     <= 1'b1;
                end else begin
                    sof_cnt_q <= sof_cnt_q + 17'd1;
                end
            end
        end
    end

    assign sof_o = sof_q;
endmodule // pci_config_device_regs
`default_nettype wire

// File: pci_host_model.sv
// far-side bus agent: transaction starts, target-ready waits, retries
`timescale 1ns/1ns
`default_nettype none
module pci_host_model (
    input  wire logic clk_i,       // bus clock
    output logic      txn_start_o, // start pulse
    output logic      trdy_wait_o, // wait level
    output logic      retry_o      // retry pulse
);
    initial begin
        txn_start_o = 1'b0;
        trdy_wait_o = 1'b0;
        retry_o = 1'b0;
    end
    task automatic burst(input int waits, input int retries);
        @(negedge clk_i);
        txn_start_o = 1'b1;
        @(negedge clk_i);
        txn_start_o = 1'b0;
        trdy_wait_o = (waits > 0);
        repeat (waits) @(negedge clk_i);
        trdy_wait_o = 1'b0;
        retry_o = (retries > 0);
        repeat (retries) @(negedge clk_i);
        retry_o = 1'b0;
    endtask
endmodule // pci_host_model
`default_nettype wire

// File: pci_config_device_regs_properties.sv
// port-level assertions for the configuration register bank
`timescale 1ns/1ns
`default_nettype none
`include "pci_dev_cfg.svh"
module pci_config_device_regs_chk
    import pci_dev_pkg::*;
#(
    parameter bit HS_FUNC = 1'b1
) (
    input wire logic        clk_i,                      // clock
    input wire logic        nrst_i,                     // reset
    input wire logic        cfg_req_i,                  // strobe
    input wire logic        cfg_we_i,                   // write
    input wire logic [7:0]  cfg_addr_i,                 // address
    input wire logic        cfg_ack_o,                  // ack
    input wire logic [31:0] cfg_rdata_o,                // read data
    input wire logic        trdy_wait_i,                // wait
    input wire logic        retry_i,                    // retry
    input wire logic        err_clear_i,                // clear
    input wire logic        unrecoverable_error_flag_o, // flag
    input wire logic        sof_o,                      // frame pulse
    input wire logic [7:0]  interrupt_pin_select_o      // pin
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_rd(logic [5:0] dw);
        cfg_req_i && !cfg_we_i && cfg_addr_i[7:2] == dw;
    endsequence
    sequence s_quiet;
        !sof_o [*8];
    endsequence
    property p_pin; interrupt_pin_select_o == `RST_INT_PIN; endproperty
    property p_ack; 1'b1 |=> cfg_ack_o == $past(cfg_req_i); endproperty
    property p_hints;
        s_rd(6'h0f) |=> cfg_rdata_o[31:16] == (HS_FUNC ? {`HS_LAT_HINT, `HS_GRANT_HINT}
                                                       : {`FS_LAT_HINT, `FS_GRANT_HINT});
    endproperty
    property p_release; s_rd(6'h18) |=> cfg_rdata_o[7:0] == (HS_FUNC ? `RST_RELEASE : 8'h00); endproperty
    property p_cap; s_rd(6'h37) |=> cfg_rdata_o[15:0] == {`RST_PM_NEXT, `RST_PM_POWER_CAP_IDENTIFIER}; endproperty
    property p_cause;
        $rose(unrecoverable_error_flag_o) |->
            $past(trdy_wait_i) || $past(retry_i) || $past(trdy_wait_i, 2) || $past(retry_i, 2);
    endproperty
    property p_sticky; unrecoverable_error_flag_o && !err_clear_i |=> unrecoverable_error_flag_o; endproperty
    property p_clear; $fell(unrecoverable_error_flag_o) |-> $past(err_clear_i); endproperty
    property p_sof_gap; sof_o |=> s_quiet; endproperty
    property p_hold; !(cfg_req_i && !cfg_we_i) |=> $stable(cfg_rdata_o); endproperty
    a_pin: assert property (p_pin) else $error("pin byte wrong");
    a_ack: assert property (p_ack) else $error("ack timing wrong");
    a_hints: assert property (p_hints) else $error("hint bytes wrong");
    a_release: assert property (p_release) else $error("release byte wrong");
    a_cap: assert property (p_cap) else $error("capability bytes wrong");
    a_cause: assert property (p_cause) else $error("flag rose without cause");
    a_sticky: assert property (p_sticky) else $error("flag dropped");
    a_clear: assert property (p_clear) else $error("flag fell without clear");
    a_sof_gap: assert property (p_sof_gap) else $error("frame pulse too close");
    a_hold: assert property (p_hold) else $error("read data moved");
endmodule // pci_config_device_regs_chk
bind pci_config_device_regs pci_config_device_regs_chk #(.HS_FUNC(HS_FUNC)) chk (
    .clk_i                      (clk_i),
    .nrst_i                     (nrst_i),
    .cfg_req_i                  (cfg_req_i),
    .cfg_we_i                   (cfg_we_i),
    .cfg_addr_i                 (cfg_addr_i),
    .cfg_ack_o                  (cfg_ack_o),
    .cfg_rdata_o                (cfg_rdata_o),
    .trdy_wait_i                (trdy_wait_i),
    .retry_i                    (retry_i),
    .err_clear_i                (err_clear_i),
    .unrecoverable_error_flag_o (unrecoverable_error_flag_o),
    .sof_o                      (sof_o),
    .interrupt_pin_select_o     (interrupt_pin_select_o)
);
`default_nettype wire

// File: pci_config_device_regs_tb_top.sv
// self-checking bench for the configuration register bank
`timescale 1ns/1ns
`default_nettype none
`include "pci_dev_cfg.svh"
module pci_config_device_regs_tb_top;
    import pci_dev_pkg::*;
    logic       clk_i = 1'b0;
    logic       nrst_i = 1'b0;
    logic       req = 1'b0;
    logic       we = 1'b0;
    byte_t      addr = 8'h00;
    logic [3:0] be = 4'h0;
    dword_t     wdata = '0;
    logic       clr = 1'b0;
    logic       sof_en = 1'b1;
    logic       ack, flag, sof, txn, waitc, rtry;
    dword_t     rdata;
    byte_t      pin;
    int         fails = 0, tests_run = 0, cyc = 0, en_cnt = 0, sof_at = -1;
    always #20 clk_i = ~clk_i;
    pci_host_model host (.clk_i(clk_i), .txn_start_o(txn), .trdy_wait_o(waitc), .retry_o(rtry));
    pci_config_device_regs #(.HS_FUNC(1'b1)) dut (.clk_i(clk_i), .nrst_i(nrst_i), .cfg_req_i(req),
        .cfg_we_i(we), .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wdata), .cfg_ack_o(ack),
        .cfg_rdata_o(rdata), .txn_start_i(txn), .trdy_wait_i(waitc), .retry_i(rtry), .err_clear_i(clr),
        .unrecoverable_error_flag_o(flag), .sof_clk_en_i(sof_en), .sof_o(sof), .interrupt_pin_select_o(pin));
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input dword_t got, input dword_t exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle strobe, answer one clock later
    task automatic cfg(input logic w, input byte_t a, input logic [3:0] b, input dword_t d);
        @(negedge clk_i);
        req = 1'b1;
        we = w;
        addr = a;
        be = b;
        wdata = d;
        @(negedge clk_i);
        req = 1'b0;
        chk({31'h0, ack}, 32'h1);
    endtask
    task automatic rd(input byte_t a, input dword_t m, input dword_t e);
        cfg(1'b0, a, 4'h0, 32'h0);
        chk(rdata & m, e);
    endtask
    task automatic run(input int w, input int r, input logic e);
        host.burst(w, r);
        repeat (2) @(negedge clk_i);
        chk({31'h0, flag}, {31'h0, e});
    endtask
    task automatic clear_flag;
        @(negedge clk_i);
        clr = 1'b1;
        @(negedge clk_i);
        clr = 1'b0;
        @(negedge clk_i);
        chk({31'h0, flag}, 32'h0);
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (nrst_i) en_cnt++;
        if (cyc == 80000) begin
            fails++;
            print_verdict();
        end
    end
    always @(negedge clk_i) begin
        if (sof === 1'b1 && sof_at < 0) sof_at = en_cnt;
    end
    initial begin
        repeat (6) @(negedge clk_i);
        nrst_i = 1'b1;
        chk({24'h0, pin}, {24'h0, `RST_INT_PIN});
        rd(`CFG_OFF_RELEASE, 32'hffffffff, 32'h0007_2020);
        cfg(1'b1, `CFG_OFF_FRAME_LENGTH_ADJUST, 4'b0010, 32'h0);
        rd(`CFG_OFF_INT_LINE, 32'hffffffff, 32'h1002_0100);
        rd(`CFG_OFF_TRDY_TO, 32'hffffffff, 32'h0000_8000);
        rd(`CFG_OFF_PM_CAP, 32'h0000ffff, 32'h0000_0001);
        rd(8'h80, 32'hffffffff, 32'h0);
        cfg(1'b1, `CFG_OFF_RELEASE, 4'b1101, 32'hffff_0055);
        rd(`CFG_OFF_RELEASE, 32'hffffffff, 32'hffff_0020);
        cfg(1'b1, `CFG_OFF_INT_LINE, 4'hf, 32'hffffffff);
        rd(`CFG_OFF_INT_LINE, 32'hffffff00, 32'h1002_0100);
        cfg(1'b1, `CFG_OFF_TRDY_TO, 4'b0011, 32'h0000_0200);
        rd(`CFG_OFF_TRDY_TO, 32'hffffffff, 32'h0000_0200);
        run(0, 2, 1'b0);
        run(0, 3, 1'b1);
        clear_flag();
        run(0, 2, 1'b0);
        run(0, 2, 1'b0);
        cfg(1'b1, `CFG_OFF_TRDY_TO, 4'b0011, 32'h0000_0001);
        run(32, 0, 1'b0);
        run(33, 0, 1'b1);
        clear_flag();
        run(0, 200, 1'b0);
        cfg(1'b1, `CFG_OFF_TRDY_TO, 4'b0001, 32'h0);
        run(300, 0, 1'b0);
        // pulse is seen in the cycle after the last enable, so the count equals the frame length
        wait (sof_at >= 0);
        chk(sof_at, 32'(`SOF_BASE_CYCLES));
        print_verdict();
    end
endmodule // pci_config_device_regs_tb_top
`default_nettype wire
